/* hw/prgs_pkg.sv */
// Package with rail indices, timing constants and state encoding of the power-on reset block
package prgs_pkg;

  // ****************************************
  // Monitored rails
  // ****************************************
  localparam int unsigned NUM_RAILS          = 9;
  localparam int unsigned RAIL_MGR_CORE      = 0; // manager_core_rail
  localparam int unsigned RAIL_PERIPH_XTOR   = 1; // periphery_transistor_rail
  localparam int unsigned RAIL_MGR_IO        = 2;
  localparam int unsigned RAIL_CONVERTER     = 3; // converter_supply_rail
  localparam int unsigned RAIL_BATTERY       = 4;
  localparam int unsigned RAIL_CORE          = 5;
  localparam int unsigned RAIL_MGR_HIGH      = 6; // manager_high_rail
  localparam int unsigned RAIL_PROC_CORE     = 7; // processor_system_core_rail
  localparam int unsigned RAIL_MGR_PIN_IO    = 8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ        = 50_000_000;
  localparam int unsigned RAMP_WINDOW_MS     = 10;   // supply_ramp_window
  localparam int unsigned RAMP_WINDOW_CYC    = RAMP_WINDOW_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned POR_DELAY_US       = 1000;
  localparam int unsigned POR_DELAY_CYC      = POR_DELAY_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned CNT_W              = 32;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic        RST_RESET_N        = 1'b0;
  localparam logic        RST_DRIVE_EN       = 1'b0;
  localparam logic        RST_CFG_START      = 1'b0;
  localparam logic        RST_RAMP_FAIL      = 1'b0;

  // ****************************************
  // States (Gray along the usual path)
  // ****************************************
  typedef enum logic [1:0] {
    PRGS_WAIT_RAILS = 2'b00,
    PRGS_DELAY      = 2'b01,
    PRGS_RUN        = 2'b11,
    PRGS_FAIL       = 2'b10
  } prgs_state_t;

endpackage

/* hw/prgs_det_if.sv */
// Interface carrying the synchronised rail detector status between modules
interface prgs_det_if #(
  parameter int unsigned N = 9
);
  logic [N-1:0] rail_good;
  logic         all_good;
  logic         any_good;

  modport src (output rail_good, output all_good, output any_good);
  modport dst (input rail_good, input all_good, input any_good);
endinterface

/* hw/prgs_rail_sync.sv */
// Per-rail detector synchroniser and gating of all detector outputs
module prgs_rail_sync #(
  parameter int unsigned N = 9
) (
  input  wire logic   clk_sys,   // System clock
  input  wire logic   rst_n,     // Async reset, active low
  input  wire logic [N-1:0] det_in,    // Raw detector trip outputs
  prgs_det_if.src           det        // Synchronised status
);

  logic [N-1:0] meta_ff;
  logic [N-1:0] sync_ff;

  // ****************************************
  // Two-stage synchroniser per rail
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_rail
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[g] <= 1'b0;
          sync_ff[g] <= 1'b0;
        end else begin
          meta_ff[g] <= det_in[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign det.rail_good = sync_ff;
  assign det.all_good  = &sync_ff;
  assign det.any_good  = |sync_ff;

endmodule

/* hw/prgs_por_ctrl.sv */
// Power-on reset controller: detector gating, ramp window watch and release delay
module prgs_por_ctrl #(
  parameter int unsigned NUM_RAILS     = prgs_pkg::NUM_RAILS,
  parameter int unsigned RAMP_WIN_CYC  = prgs_pkg::RAMP_WINDOW_CYC,
  parameter int unsigned POR_DLY_CYC   = prgs_pkg::POR_DELAY_CYC
) (
  input  wire logic                 clk_sys,         // System clock, 50 MHz
  input  wire logic                 rst_n,           // Async reset, active low
  input  wire logic [NUM_RAILS-1:0] rail_det_in,     // Per-rail trip detector outputs
  output logic                      dev_reset_n_ff,  // Device internal reset, active low
  output logic                      pin_drive_en_ff, // Pins and prog registers leave tri-state
  output logic                      cfg_start_ff,    // One-cycle pulse: begin configuration
  output logic                      ramp_fail_ff,    // Ramp window missed
  output logic [NUM_RAILS-1:0]      rail_good_ff     // Synchronised per-rail status
);

  localparam logic [prgs_pkg::CNT_W-1:0] RAMP_LIM = prgs_pkg::CNT_W'(RAMP_WIN_CYC - 1);
  localparam logic [prgs_pkg::CNT_W-1:0] DLY_LIM  = prgs_pkg::CNT_W'(POR_DLY_CYC - 1);

  prgs_det_if #(.N(NUM_RAILS)) det_bus ();

  // ****************************************
  // Detector synchronisers
  // ****************************************
  // nine rails watched
  prgs_rail_sync #(.N(NUM_RAILS)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .det_in  (rail_det_in),
    .det     (det_bus.src)
  );

  prgs_pkg::prgs_state_t       state_ff;
  prgs_pkg::prgs_state_t       nxt_state;
  logic [prgs_pkg::CNT_W-1:0]  ramp_cnt_ff;
  logic [prgs_pkg::CNT_W-1:0]  nxt_ramp_cnt;
  logic                        ramp_run_ff;
  logic                        nxt_ramp_run;
  logic [prgs_pkg::CNT_W-1:0]  dly_cnt_ff;
  logic [prgs_pkg::CNT_W-1:0]  nxt_dly_cnt;
  logic                        nxt_reset_n;
  logic                        nxt_drive_en;
  logic                        nxt_cfg_start;
  logic                        nxt_ramp_fail;

  // ****************************************
  // Decode
  // ****************************************
  wire                       all_good     = det_bus.all_good;
  wire                       any_good     = det_bus.any_good;
  wire                       ramp_out     = ramp_run_ff && (ramp_cnt_ff >= RAMP_LIM);
  wire                       dly_done     = (dly_cnt_ff >= DLY_LIM);
  wire                       in_wait      = (state_ff == prgs_pkg::PRGS_WAIT_RAILS);
  wire                       in_delay     = (state_ff == prgs_pkg::PRGS_DELAY);
  wire                       in_run       = (state_ff == prgs_pkg::PRGS_RUN);
  wire                       ramp_inc     = ramp_run_ff && in_wait && !ramp_out;
  wire                       dly_inc      = in_delay && all_good && !dly_done;
  wire                       release_now  = in_delay && all_good && dly_done;
  wire                       hold_run     = in_run && all_good;
  wire                       enter_fail   = in_wait && !all_good && ramp_out;
  wire [prgs_pkg::CNT_W-1:0] ramp_cnt_inc = prgs_pkg::CNT_W'(ramp_cnt_ff + 1'b1);
  wire [prgs_pkg::CNT_W-1:0] dly_cnt_inc  = prgs_pkg::CNT_W'(dly_cnt_ff + 1'b1);

  // ****************************************
  // Ramp window
  // ****************************************
  // Window is measured once; a rail loss later does not restart it
  assign nxt_ramp_run = ramp_run_ff | any_good;
  assign nxt_ramp_cnt = ramp_inc ? ramp_cnt_inc : ramp_cnt_ff;

  // ****************************************
  // Release delay
  // ****************************************
  // delay counted from all rails good
  assign nxt_dly_cnt  = dly_inc ? dly_cnt_inc : '0;

  // ****************************************
  // State machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      prgs_pkg::PRGS_WAIT_RAILS: begin
        if (all_good) begin
          nxt_state = prgs_pkg::PRGS_DELAY;
        end else if (ramp_out) begin
          nxt_state = prgs_pkg::PRGS_FAIL;
        end
      end
      prgs_pkg::PRGS_DELAY: begin
        if (!all_good) begin
          nxt_state = prgs_pkg::PRGS_WAIT_RAILS;
        end else if (dly_done) begin
          nxt_state = prgs_pkg::PRGS_RUN;
        end
      end
      prgs_pkg::PRGS_RUN: begin
        if (!all_good) begin
          nxt_state = prgs_pkg::PRGS_WAIT_RAILS;
        end
      end
      prgs_pkg::PRGS_FAIL: begin
        nxt_state = prgs_pkg::PRGS_FAIL;
      end
      default: begin
        nxt_state = prgs_pkg::PRGS_WAIT_RAILS;
      end
    endcase
  end

  assign nxt_reset_n   = release_now || hold_run;
  assign nxt_drive_en  = nxt_reset_n && (nxt_state != prgs_pkg::PRGS_FAIL);
  assign nxt_cfg_start = release_now;
  // Sticky: only rst_n clears the window fault
  assign nxt_ramp_fail = ramp_fail_ff || enter_fail;

  // ****************************************
  // State registers
  // ****************************************
  // Sequencer state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= prgs_pkg::PRGS_WAIT_RAILS;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Ramp window cycle count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ramp_cnt_ff <= '0;
    end else begin
      ramp_cnt_ff <= nxt_ramp_cnt;
    end
  end

  // Ramp window armed by first trip
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ramp_run_ff <= 1'b0;
    end else begin
      ramp_run_ff <= nxt_ramp_run;
    end
  end

  // Release delay count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dly_cnt_ff <= '0;
    end else begin
      dly_cnt_ff <= nxt_dly_cnt;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Internal device reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dev_reset_n_ff <= prgs_pkg::RST_RESET_N;
    end else begin
      dev_reset_n_ff <= nxt_reset_n;
    end
  end

  // Pin and register drive enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_drive_en_ff <= prgs_pkg::RST_DRIVE_EN;
    end else begin
      pin_drive_en_ff <= nxt_drive_en;
    end
  end

  // Configuration start pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_start_ff <= prgs_pkg::RST_CFG_START;
    end else begin
      cfg_start_ff <= nxt_cfg_start;
    end
  end

  // Window fault flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ramp_fail_ff <= prgs_pkg::RST_RAMP_FAIL;
    end else begin
      ramp_fail_ff <= nxt_ramp_fail;
    end
  end

  // Per-rail status copy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rail_good_ff <= '0;
    end else begin
      rail_good_ff <= det_bus.rail_good;
    end
  end

endmodule

/* verif/prgs_por_monitor.sv */
// Checker for reset gating, release delay and ramp window
module prgs_por_monitor #(
  parameter int unsigned NUM_RAILS    = 9,
  parameter int unsigned RAMP_WIN_CYC = 40,
  parameter int unsigned POR_DLY_CYC  = 8
) (
  input wire logic                 clk_sys,         // Clock
  input wire logic                 rst_n,           // Reset
  input wire logic [NUM_RAILS-1:0] rail_det_in,     // Detectors
  input wire logic                 dev_reset_n_ff,  // Device reset
  input wire logic                 pin_drive_en_ff, // Pin drive
  input wire logic                 cfg_start_ff,    // Config start
  input wire logic                 ramp_fail_ff,    // Window missed
  input wire logic [NUM_RAILS-1:0] rail_good_ff     // Synced status
);
  logic [15:0] ok_cnt_ff;
  logic [15:0] age_cnt_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ok_cnt_ff  <= 16'h0000;
      age_cnt_ff <= 16'h0000;
    end else begin
      ok_cnt_ff  <= (&rail_det_in) ? ok_cnt_ff + 16'h0001 : 16'h0000;
      age_cnt_ff <= (|rail_det_in || age_cnt_ff != 16'h0000) ? age_cnt_ff + 16'h0001 : age_cnt_ff;
    end
  end
  sequence s_cfg_pulse;
    cfg_start_ff ##1 !cfg_start_ff;
  endsequence
  AST_HOLD_ON_DROP: assert property ($fell(&rail_det_in) |-> ##[1:4] !dev_reset_n_ff)
    else $error("reset not asserted after rail drop");
  AST_ALL_GATED: assert property (dev_reset_n_ff |-> &$past(rail_good_ff, 2))
    else $error("reset released with a rail not good");
  AST_FAIL_TRISTATE: assert property (ramp_fail_ff |-> !pin_drive_en_ff && !cfg_start_ff)
    else $error("pins driven after window missed");
  AST_FAIL_STICKY: assert property (ramp_fail_ff |=> ramp_fail_ff)
    else $error("window fault cleared without reset");
  AST_FAIL_MOMENT: assert property ($rose(ramp_fail_ff) |-> age_cnt_ff >= RAMP_WIN_CYC && age_cnt_ff <= RAMP_WIN_CYC + 5)
    else $error("window fault at wrong time");
  AST_PIN_IN_RESET: assert property (pin_drive_en_ff |-> dev_reset_n_ff)
    else $error("pins driven in reset");
  AST_CFG_AT_RELEASE: assert property ($rose(dev_reset_n_ff) |-> s_cfg_pulse)
    else $error("no single config pulse at release");
  AST_CFG_ONLY_RELEASE: assert property (cfg_start_ff |-> $rose(dev_reset_n_ff))
    else $error("config pulse without release");
  AST_DELAY_LEN: assert property ($rose(dev_reset_n_ff) |-> ok_cnt_ff >= POR_DLY_CYC + 2 && ok_cnt_ff <= POR_DLY_CYC + 4)
    else $error("release delay wrong");
endmodule
bind prgs_por_ctrl prgs_por_monitor #(.NUM_RAILS(NUM_RAILS), .RAMP_WIN_CYC(RAMP_WIN_CYC), .POR_DLY_CYC(POR_DLY_CYC))
  prgs_por_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n), .rail_det_in(rail_det_in), .dev_reset_n_ff(dev_reset_n_ff),
  .pin_drive_en_ff(pin_drive_en_ff), .cfg_start_ff(cfg_start_ff), .ramp_fail_ff(ramp_fail_ff), .rail_good_ff(rail_good_ff));

/* verif/prgs_supply_model.sv */
// Supply controller model ramping rail groups in order
module prgs_supply_model (
  input  wire logic       clk_sys,  // Clock
  input  wire logic       go,       // Power up when high
  input  wire logic [31:0] gap,     // Cycles between groups
  input  wire logic [8:0] skip,     // Rails held low
  output logic [8:0]      rail_det  // Detector levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] lvl;
  assign rail_det = lvl & ~skip;
  initial begin
    lvl = 9'h000;
    forever begin
      @(negedge clk_sys);
      if (go && lvl == 9'h000) begin
        lvl = 9'h0f1;
        repeat (gap) @(negedge clk_sys);
        if ((rail_det & 9'h0e1) == 9'h0e1) lvl |= 9'h00a;
        repeat (gap) @(negedge clk_sys);
        if ((rail_det & 9'h00a) == 9'h00a) lvl |= 9'h104;
      end else if (!go && lvl != 9'h000) begin
        lvl &= 9'h0fb;
        @(negedge clk_sys);
        lvl &= 9'h0f1;
        @(negedge clk_sys);
        lvl = 9'h000;
      end
    end
  end
endmodule

/* verif/tb_top.sv */
// Testbench for the power-on reset controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 1'b0;
  logic       rst_n   = 1'b0;
  logic       go      = 1'b0;
  int         gap     = 2;
  logic [8:0] skip    = 9'h000;
  logic [8:0] det;
  logic [8:0] good;
  logic       rst_o, pin, cfg, fail;
  int         n_fail = 0, n_checks = 0, seed = 51, k, i;
  always #10 clk_sys = ~clk_sys;
  prgs_supply_model prgs_supply_model_inst (.clk_sys(clk_sys), .go(go), .gap(gap), .skip(skip), .rail_det(det));
  prgs_por_ctrl #(.RAMP_WIN_CYC(40), .POR_DLY_CYC(8)) prgs_por_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .rail_det_in(det), .dev_reset_n_ff(rst_o), .pin_drive_en_ff(pin), .cfg_start_ff(cfg), .ramp_fail_ff(fail),
    .rail_good_ff(good));
  task check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task restart(input int g, input logic [8:0] s);
    @(negedge clk_sys);
    rst_n = 1'b0;
    go = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    gap = g;
    skip = s;
    go = 1'b1;
  endtask
  task wait_cfg;
    for (i = 0; i < 80 && cfg !== 1'b1; i++) @(negedge clk_sys);
    if (cfg !== 1'b1) begin
      n_fail++;
      summarize();
    end
    check("release", {5'h00, rst_o, pin, fail, 1'b1}, 9'h00d);
    check("good", good, 9'h1ff);
    @(negedge clk_sys);
    check("pulse", cfg, 1'b0);
  endtask
  initial begin
    for (k = 0; k < 3; k++) begin
      restart({$random(seed)} % 8 + 1, 9'h000);
      repeat (2) @(negedge clk_sys);
      check("hold", rst_o, 1'b0);
      wait_cfg();
      skip = 9'h001 << ({$random(seed)} % 9);
      repeat (5) @(negedge clk_sys);
      check("drop", {rst_o, pin}, 2'b00);
      check("drop_good", good, ~skip);
      skip = 9'h000;
      wait_cfg();
    end
    for (k = 0; k < 9; k++) begin
      restart(2, 9'h001 << k);
      repeat (20) @(negedge clk_sys);
      check("one_low", {rst_o, pin, good[k]}, 3'b000);
    end
    restart(30, 9'h000);
    repeat (90) @(negedge clk_sys);
    check("late", {5'h00, rst_o, pin, cfg, fail}, 9'h001);
    check("late_good", good, 9'h1ff);
    restart(2, 9'h000);
    wait_cfg();
    summarize();
  end
endmodule
